// ### rtl/ftc_xcvr.sv
`timescale 1ns/1ps
module ftc_xcvr
  import ftc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  ftc_link_if.xcvr                    lnk,
  input  wire logic [NCH-1:0]         ls_tick,
  input  wire logic                   bond_tick,
  input  wire logic [NCH-1:0]         rec_tick,
  input  wire logic [NCH-1:0][DW-1:0] pcs_rx_data,
  input  wire logic                   cfg_bonded,
  input  wire logic                   cfg_rate_match,
  input  wire logic                   cfg_tx_used,
  input  wire logic                   cfg_rx_used,
  input  wire logic                   cfg_byte_ser,
  input  wire logic                   cfg_usr_tx_clk,
  input  wire logic                   cfg_usr_rx_clk,
  output logic [NCH-1:0][DW-1:0]      pcs_tx_data,
  output logic [NCH-1:0]              tx_pcs_tick,
  output logic [NCH-1:0]              rx_wr_tick,
  output logic                        rx_detect_tick,
  output logic                        cal_busy,
  output logic                        cal_done,
  output logic                        ofs_done
);

  typedef struct packed {
    logic                   cfg_valid;
    logic                   bonded;
    logic                   rate_match;
    logic                   byte_ser;
    logic                   usr_tx;
    logic                   usr_rx;
    logic                   half;
    logic [NCH-1:0][DW-1:0] tx_fifo;
    logic [NCH-1:0][DW-1:0] tx_out;
    logic [NCH-1:0][DW-1:0] rx_fifo;
    logic [NCH-1:0][DW-1:0] rx_out;
    ftc_cal_e               cal_st;
    logic [CNT_W-1:0]       cal_cnt;
    logic                   pd_prev;
    logic [CNT_W-1:0]       ofs_cnt;
    logic                   ofs_done;
  } ftc_xcvr_s;

  ftc_xcvr_s st_r;
  ftc_xcvr_s st_nxt;

  logic           bond_half;
  logic [NCH-1:0] tx_wr;
  logic [NCH-1:0] tx_rd;
  logic [NCH-1:0] rx_wr;
  logic [NCH-1:0] rx_rd;
  logic [NCH-1:0] rm_tick;

  // halved bonded clock: every second bonded edge when serializer is on
  assign bond_half = bond_tick & st_r.half;

  // per-channel clock routing from the latched configuration only
  for (genvar c = 0; c < NCH; c++) begin : g_route
    // bonded channels share the common low-speed path for lower skew
    assign rm_tick[c] = st_r.bonded ? bond_tick : ls_tick[c];

    // tx read clock; halved only on the bonded path
    assign tx_rd[c] = !st_r.bonded ? ls_tick[c] :
                      st_r.byte_ser ? bond_half : bond_tick;

    // tx write clock: user port, else auto by bonding
    assign tx_wr[c] = st_r.usr_tx ? lnk.tx_coreclk[c] :
                      st_r.bonded ? bond_tick :
                      ls_tick[c];

    // rx write clock follows the rate match choice
    assign rx_wr[c] = st_r.rate_match ? rm_tick[c] : rec_tick[c];

    // rx read clock: user port, else the same auto source
    assign rx_rd[c] = st_r.usr_rx ? lnk.rx_coreclk[c] :
                      st_r.rate_match ? rm_tick[c] :
                      rec_tick[c];
  end

  // clocks forwarded to the fabric
  always_comb begin
    lnk.tx_clkout  = ls_tick;
    lnk.coreclkout = bond_tick;
    lnk.rx_clkout  = rec_tick;
  end

  // next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;

    // straps latched once after reset, then frozen
    if (!st_r.cfg_valid) begin
      st_nxt.cfg_valid  = 1'b1;
      st_nxt.bonded     = cfg_bonded & cfg_tx_used;
      st_nxt.rate_match = cfg_rate_match & cfg_tx_used
                          & cfg_rx_used;
      st_nxt.byte_ser   = cfg_byte_ser;
      st_nxt.usr_tx     = cfg_usr_tx_clk;
      st_nxt.usr_rx     = cfg_usr_rx_clk;
    end

    // divide-by-two phase for the bonded clock
    if (bond_tick) begin
      st_nxt.half = ~st_r.half;
    end

    // phase compensation fifo stages, one word deep each
    for (int c = 0; c < NCH; c++) begin
      if (tx_wr[c]) begin
        st_nxt.tx_fifo[c] = lnk.tx_data[c];
      end
      if (tx_rd[c]) begin
        st_nxt.tx_out[c] = st_r.tx_fifo[c];
      end
      if (rx_wr[c]) begin
        st_nxt.rx_fifo[c] = pcs_rx_data[c];
      end
      if (rx_rd[c]) begin
        st_nxt.rx_out[c] = st_r.rx_fifo[c];
      end
    end

    // shared calibration sequencer, one for all channels
    st_nxt.pd_prev = lnk.cal_blk_powerdown;
    case (st_r.cal_st)
      CAL_OFF: begin
        st_nxt.cal_cnt = '0;
        if (!lnk.cal_blk_powerdown) begin
          st_nxt.cal_st = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (lnk.cal_blk_clk) begin
          st_nxt.cal_cnt = st_r.cal_cnt + 1'b1;
          if (st_r.cal_cnt == CNT_W'(CAL_TICKS - 1)) begin
            st_nxt.cal_st = CAL_DONE;
          end
        end
      end
      CAL_DONE: begin
        st_nxt.cal_cnt = st_r.cal_cnt;
      end
      default: begin
        st_nxt.cal_st = CAL_OFF;
      end
    endcase
    // powerdown always wins; its release starts a fresh sequence
    if (lnk.cal_blk_powerdown) begin
      st_nxt.cal_st  = CAL_OFF;
      st_nxt.cal_cnt = '0;
    end else if (st_r.pd_prev) begin
      st_nxt.cal_st  = CAL_RUN;
      st_nxt.cal_cnt = '0;
    end

    // offset cancellation paced by the free-running reconfig clock
    if (!st_r.ofs_done && lnk.reconfig_clk) begin
      st_nxt.ofs_cnt = st_r.ofs_cnt + 1'b1;
      if (st_r.ofs_cnt == CNT_W'(OFS_TICKS - 1)) begin
        st_nxt.ofs_done = 1'b1;
      end
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs; data from flip-flops, ticks are plain enables
  always_comb begin
    lnk.rx_data    = st_r.rx_out;
    pcs_tx_data    = st_r.tx_out;
    tx_pcs_tick    = tx_rd;       // tx pcs runs on the tx read clock
    rx_wr_tick     = rx_wr;
    rx_detect_tick = lnk.fixed_clk;
    cal_busy       = (st_r.cal_st == CAL_RUN);
    cal_done       = (st_r.cal_st == CAL_DONE);
    ofs_done       = st_r.ofs_done;
  end

endmodule

// ### rtl/ftc_pkg.sv
package ftc_pkg;
  // channel count and parallel data width of one transceiver block
  localparam int NCH = 4;
  localparam int DW  = 8;

  // core clock rate; every slower clock is an enable pulse from it
  localparam int CLK_HZ = 20_000_000;

  // fabric-side clock targets
  localparam int FIXED_CLK_HZ   = 125_000_000;
  localparam int CAL_CLK_MAX_HZ = 125_000_000;

  // divider for the calibration clock; never faster than its limit
  localparam int CAL_DIV_MIN = (CLK_HZ + CAL_CLK_MAX_HZ - 1) / CAL_CLK_MAX_HZ;
  localparam int CAL_DIV     = (CAL_DIV_MIN > 4) ? CAL_DIV_MIN : 4;
  localparam int CAL_DIV_W   = 4;

  // free-running reconfiguration clock divider
  localparam int RCFG_DIV   = 2;
  localparam int RCFG_DIV_W = 4;

  // calibration and offset cancellation lengths in their own clock ticks
  localparam int CAL_TICKS = 16;
  localparam int OFS_TICKS = 32;
  localparam int CNT_W     = 8;

  // calibration sequencer states
  typedef enum logic [1:0] {
    CAL_OFF,
    CAL_RUN,
    CAL_DONE
  } ftc_cal_e;
endpackage

// ### rtl/ftc_link_if.sv
`timescale 1ns/1ps
interface ftc_link_if;
  import ftc_pkg::*;
  // transceiver to fabric clocks (one-cycle enables)
  logic [NCH-1:0]         tx_clkout;
  logic [NCH-1:0]         rx_clkout;
  logic                   coreclkout;
  // fabric to transceiver clocks and control
  logic [NCH-1:0]         tx_coreclk;
  logic [NCH-1:0]         rx_coreclk;
  logic                   fixed_clk;
  logic                   reconfig_clk;
  logic                   cal_blk_clk;
  logic                   cal_blk_powerdown;
  // datapath words across the phase compensation fifos
  logic [NCH-1:0][DW-1:0] tx_data;
  logic [NCH-1:0][DW-1:0] rx_data;

  modport xcvr (
    output tx_clkout, rx_clkout, coreclkout, rx_data,
    input  tx_coreclk, rx_coreclk, fixed_clk, reconfig_clk,
    input  cal_blk_clk, cal_blk_powerdown, tx_data
  );
  modport fabric (
    input  tx_clkout, rx_clkout, coreclkout, rx_data,
    output tx_coreclk, rx_coreclk, fixed_clk, reconfig_clk,
    output cal_blk_clk, cal_blk_powerdown, tx_data
  );
endinterface

// ### rtl/ftc_fabric.sv
`timescale 1ns/1ps
// fabric end: drives the transceiver-bound clocks, moves user data
module ftc_fabric
  import ftc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  ftc_link_if.fabric                  lnk,
  input  wire logic                   cfg_bonded,
  input  wire logic                   cfg_rate_match,
  input  wire logic                   cfg_usr_tx_clk,
  input  wire logic                   cfg_usr_rx_clk,
  input  wire logic                   cal_pd_req,
  input  wire logic [NCH-1:0][DW-1:0] usr_tx_data,
  output logic [NCH-1:0]              usr_tx_take,
  output logic [NCH-1:0][DW-1:0]      usr_rx_data,
  output logic [NCH-1:0]              usr_rx_valid
);

  typedef struct packed {
    logic [CAL_DIV_W-1:0]   cal_div;
    logic [RCFG_DIV_W-1:0]  rcfg_div;
    logic                   cal_pd;
    logic [NCH-1:0][DW-1:0] tx_word;
    logic [NCH-1:0][DW-1:0] rx_word;
  } ftc_fabric_s;

  ftc_fabric_s st_r;
  ftc_fabric_s st_nxt;

  logic [NCH-1:0] tx_wr;
  logic [NCH-1:0] rx_rd;
  logic           cal_tick;
  logic           rcfg_tick;

  // user clocks derived from the device clocks, so zero offset
  for (genvar c = 0; c < NCH; c++) begin : g_clk
    assign lnk.tx_coreclk[c] = cfg_bonded ? lnk.coreclkout
                                          : lnk.tx_clkout[c];
    assign lnk.rx_coreclk[c] = !cfg_rate_match ? lnk.rx_clkout[c] :
                               cfg_bonded ? lnk.coreclkout
                                          : lnk.tx_clkout[c];
    assign tx_wr[c] = cfg_usr_tx_clk ? lnk.tx_coreclk[c] :
                      cfg_bonded ? lnk.coreclkout : lnk.tx_clkout[c];
    assign rx_rd[c] = cfg_usr_rx_clk ? lnk.rx_coreclk[c] :
                      !cfg_rate_match ? lnk.rx_clkout[c] :
                      cfg_bonded ? lnk.coreclkout : lnk.tx_clkout[c];
  end

  // dividers end on their last count
  assign cal_tick  = (st_r.cal_div == CAL_DIV_W'(CAL_DIV - 1));
  assign rcfg_tick = (st_r.rcfg_div == RCFG_DIV_W'(RCFG_DIV - 1));

  // next state: dividers, powerdown register, data words
  always_comb begin
    st_nxt          = st_r;
    st_nxt.cal_div  = cal_tick ? '0 : st_r.cal_div + 1'b1;
    st_nxt.rcfg_div = rcfg_tick ? '0 : st_r.rcfg_div + 1'b1;
    st_nxt.cal_pd   = cal_pd_req;
    for (int c = 0; c < NCH; c++) begin
      if (tx_wr[c]) begin
        st_nxt.tx_word[c] = usr_tx_data[c];
      end
      if (rx_rd[c]) begin
        st_nxt.rx_word[c] = lnk.rx_data[c];
      end
    end
  end

  // powerdown held high in reset so calibration starts on release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r        <= '0;
      st_r.cal_pd <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // drives toward the transceiver; rx detect clock at full enable rate
  always_comb begin
    lnk.fixed_clk         = 1'b1;
    lnk.reconfig_clk      = rcfg_tick; // free running, never gated
    lnk.cal_blk_clk       = cal_tick;
    lnk.cal_blk_powerdown = st_r.cal_pd;
    lnk.tx_data           = st_r.tx_word;
    usr_tx_take           = tx_wr;
    usr_rx_data           = st_r.rx_word;
    usr_rx_valid          = rx_rd;
  end

endmodule

// ### testbench/ftc_link_sva.sv
`timescale 1ns/1ps
// watches the link between the two ends; sees interface signals only
module ftc_link_sva
  import ftc_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic [NCH-1:0]         tx_clkout,
  input wire logic [NCH-1:0]         rx_clkout,
  input wire logic                   coreclkout,
  input wire logic [NCH-1:0]         tx_coreclk,
  input wire logic [NCH-1:0]         rx_coreclk,
  input wire logic                   fixed_clk,
  input wire logic                   reconfig_clk,
  input wire logic                   cal_blk_clk,
  input wire logic                   cal_blk_powerdown,
  input wire logic [NCH-1:0][DW-1:0] tx_data,
  input wire logic [NCH-1:0][DW-1:0] rx_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // words only move after some clock edge of the matching fifo side
  tx_take_tick_a: assert property ($changed(tx_data) |->
    $past(tx_clkout) != '0 || $past(coreclkout) || $past(tx_coreclk) != '0)
    else $error("tx word moved without a write clock");
  rx_show_tick_a: assert property ($changed(rx_data) |->
    $past(rx_clkout) != '0 || $past(tx_clkout) != '0 ||
    $past(coreclkout) || $past(rx_coreclk) != '0)
    else $error("rx word moved without a read clock");
  // user clocks are zero-offset copies, never extra edges
  tx_user_clk_a: assert property (
    (tx_coreclk & ~(tx_clkout | {NCH{coreclkout}})) == '0)
    else $error("user tx clock pulsed alone");
  rx_user_clk_a: assert property (
    (rx_coreclk & ~(rx_clkout | tx_clkout | {NCH{coreclkout}})) == '0)
    else $error("user rx clock pulsed alone");
  fixed_clk_on_a: assert property (!$past(sys_rst) |-> fixed_clk)
    else $error("detect clock stopped");
  rcfg_period_a: assert property (reconfig_clk |=>
    !reconfig_clk ##1 reconfig_clk)
    else $error("reconfig clock not free running");
  // spacing of four keeps the slow clock under its limit
  cal_clk_rate_a: assert property (cal_blk_clk |=>
    !cal_blk_clk [*3] ##1 cal_blk_clk)
    else $error("calibration clock spacing wrong");
  cal_pd_reset_a: assert property ($fell(sys_rst) |->
    cal_blk_powerdown)
    else $error("powerdown low out of reset");

  cover property ($fell(cal_blk_powerdown));
  cover property ($changed(tx_data));
  cover property ($changed(rx_data));
endmodule

// ### testbench/fabric_transceiver_clocking_bench.sv
`timescale 1ns/1ps
module fabric_transceiver_clocking_bench;
  import ftc_pkg::*;
  typedef logic [NCH-1:0][DW-1:0] ftc_word_t;
  logic           clk;
  logic           sys_rst;
  logic [NCH-1:0] ls_tick;
  logic           bond_tick;
  logic [NCH-1:0] rec_tick;
  ftc_word_t      pcs_rx_data;
  ftc_word_t      usr_tx_data;
  ftc_word_t      pcs_tx_data;
  ftc_word_t      usr_rx_data;
  logic [5:0]     cfg;
  logic           cal_pd_req;
  logic           rx_detect_tick;
  logic           cal_busy;
  logic           cal_done;
  logic           ofs_done;
  logic [NCH-1:0] tx_pcs_tick;
  int             n_rd;
  int             n_errors;
  int             checks_done;
  int             span;

  // cfg: bonded, rate match, byte ser, user tx, user rx, rx used
  ftc_link_if lnk ();
  ftc_xcvr ftc_xcvr_inst (.clk(clk), .sys_rst(sys_rst), .lnk(lnk),
    .ls_tick(ls_tick), .bond_tick(bond_tick), .rec_tick(rec_tick),
    .pcs_rx_data(pcs_rx_data), .cfg_bonded(cfg[5]),
    .cfg_rate_match(cfg[4]), .cfg_tx_used(1'h1), .cfg_rx_used(cfg[0]),
    .cfg_byte_ser(cfg[3]), .cfg_usr_tx_clk(cfg[2]),
    .cfg_usr_rx_clk(cfg[1]), .pcs_tx_data(pcs_tx_data),
    .tx_pcs_tick(tx_pcs_tick), .rx_wr_tick(),
    .rx_detect_tick(rx_detect_tick),
    .cal_busy(cal_busy), .cal_done(cal_done), .ofs_done(ofs_done));
  // fabric sees rate match only where the channel allows it
  ftc_fabric ftc_fabric_inst (.clk(clk), .sys_rst(sys_rst), .lnk(lnk),
    .cfg_bonded(cfg[5]), .cfg_rate_match(cfg[4] & cfg[0]),
    .cfg_usr_tx_clk(cfg[2]), .cfg_usr_rx_clk(cfg[1]),
    .cal_pd_req(cal_pd_req), .usr_tx_data(usr_tx_data),
    .usr_tx_take(), .usr_rx_data(usr_rx_data), .usr_rx_valid());
  ftc_link_sva ftc_link_sva_inst (.clk(clk), .sys_rst(sys_rst),
    .tx_clkout(lnk.tx_clkout), .rx_clkout(lnk.rx_clkout),
    .coreclkout(lnk.coreclkout), .tx_coreclk(lnk.tx_coreclk),
    .rx_coreclk(lnk.rx_coreclk), .fixed_clk(lnk.fixed_clk),
    .reconfig_clk(lnk.reconfig_clk), .cal_blk_clk(lnk.cal_blk_clk),
    .cal_blk_powerdown(lnk.cal_blk_powerdown), .tx_data(lnk.tx_data),
    .rx_data(lnk.rx_data));

  // 20 MHz core clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // tx read ticks of channel 0; shows whether the bonded clock is halved
  always @(posedge clk) begin
    if (tx_pcs_tick[0] === 1'h1) begin
      n_rd <= n_rd + 1;
    end
  end

  task check(input string what, input ftc_word_t exp, input ftc_word_t got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // six spaced pulses on the chosen sources: ls, bond, rec
  task pulse(input logic [2:0] m);
    repeat (6) begin
      @(posedge clk);
      ls_tick <= {NCH{m[2]}};
      bond_tick <= m[1];
      rec_tick <= {NCH{m[0]}};
      @(posedge clk);
      ls_tick <= '0;
      bond_tick <= 1'h0;
      rec_tick <= '0;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask

  // config is only taken after reset, so each mode needs one
  task do_reset;
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // wrong clocks first (nothing moves), then tx source, then rx source
  task mode(input logic [5:0] c, input logic [2:0] ts, input logic [2:0] rs,
            input logic [7:0] k);
    ftc_word_t tx;
    ftc_word_t rx;
    int        rd0;
    tx = {k, k ^ 8'h5a, k ^ 8'ha5, ~k};
    rx = ~tx;
    @(posedge clk);
    cfg <= c;
    usr_tx_data <= tx;
    pcs_rx_data <= rx;
    do_reset;
    pulse(~(ts | rs));
    check("pcs_tx_data", '0, pcs_tx_data);
    check("rx_data", '0, lnk.rx_data);
    rd0 = n_rd;
    pulse(ts);
    check("pcs_tx_data", tx, pcs_tx_data);
    check("tx read ticks", (c[5] && c[3]) ? 3 : 6, n_rd - rd0);
    check("rx_data", (ts == rs) ? rx : '0, lnk.rx_data);
    pulse(rs);
    check("rx_data", rx, lnk.rx_data);
    check("usr_rx_data", rx, usr_rx_data);
    $display("test mode %h done", c);
  endtask

  // waits for calibration to finish, bounded
  task cal_wait;
    span = 0;
    while (cal_done !== 1'h1 && span < 200) begin
      @(posedge clk);
      #1;
      span++;
    end
  endtask

  initial begin
    sys_rst = 1'h1;
    ls_tick = '0;
    bond_tick = 1'h0;
    rec_tick = '0;
    pcs_rx_data = '0;
    usr_tx_data = '0;
    cfg = 6'h01;
    cal_pd_req = 1'h1;
    n_errors = 0;
    checks_done = 0;
    // reset for two cycles at the start
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    mode(6'h01, 3'h4, 3'h1, 8'h11);
    mode(6'h11, 3'h4, 3'h4, 8'h22);
    mode(6'h21, 3'h2, 3'h1, 8'h33);
    mode(6'h31, 3'h2, 3'h2, 8'h44);
    mode(6'h3f, 3'h2, 3'h2, 8'h55);
    mode(6'h07, 3'h4, 3'h1, 8'h66);
    mode(6'h10, 3'h4, 3'h1, 8'h77);
    do_reset;
    check("cal_done", 1'h0, cal_done);
    check("ofs_done", 1'h0, ofs_done);
    check("rx_detect_tick", 1'h1, rx_detect_tick);
    @(posedge clk);
    cal_pd_req <= 1'h0;
    cal_wait;
    check("cal span", 1'h1, span >= 62 && span <= 70);
    // abort in mid-run, then a full restart is expected
    @(posedge clk);
    cal_pd_req <= 1'h1;
    repeat (2) @(posedge clk);
    cal_pd_req <= 1'h0;
    repeat (30) @(posedge clk);
    #1;
    check("cal_busy", 1'h1, cal_busy);
    @(posedge clk);
    cal_pd_req <= 1'h1;
    repeat (2) @(posedge clk);
    cal_pd_req <= 1'h0;
    cal_wait;
    check("cal restart span", 1'h1, span >= 62 && span <= 70);
    check("ofs_done", 1'h1, ofs_done);
    $display("test calibration done");
    results;
  end

  // cut a hang short
  initial begin
    #100000;
    $display("Error watchdog expected end seen hang");
    n_errors++;
    results;
  end
endmodule
